/* File: include/mhs_map.vh */
/*
 * Constants of the modem handshake supervisor: register offsets, field
 * positions, reset values, response codes and timing counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef MHS_MAP_VH
`define MHS_MAP_VH

// Clock and timebase
`define MHS_CLK_HZ              20000000
`define MHS_TICK_MS             10
`define MHS_TICK_CYCLES         ((`MHS_CLK_HZ / 1000) * `MHS_TICK_MS)
`define MHS_TICK_CNT_W          18

// Timeouts, in their own units, and as tick counts
`define MHS_CTS_TIMEOUT_S       30
`define MHS_CTS_TIMEOUT_TICKS   ((`MHS_CTS_TIMEOUT_S * 1000) / `MHS_TICK_MS)
`define MHS_CTS_CONST_MS        20
`define MHS_CTS_CONST_TICKS     (`MHS_CTS_CONST_MS / `MHS_TICK_MS)
`define MHS_TO_CNT_W            12

// Register offsets
`define MHS_REG_CTRL            8'h00
`define MHS_REG_MODEM           8'h04
`define MHS_REG_STATUS          8'h08
`define MHS_REG_RESP_STAT       8'h0c
`define MHS_REG_RESP_BYTE7      8'h10
`define MHS_REG_STATE           8'h14

// Control register fields
`define MHS_CTRL_LINE_START     0
`define MHS_CTRL_HALF_DUPLEX    1
`define MHS_CTRL_TX_REQ         2
`define MHS_CTRL_AUTO_ANSWER    3
`define MHS_CTRL_REMOTE_LOAD    4
`define MHS_CTRL_BOOT           5
`define MHS_CTRL_MASTER_CLEAR   7
`define MHS_CTRL_RESET          8'h00
`define MHS_CTRL_MASK           8'h3f

// Modem control register fields
`define MHS_MODEM_DTR           0

// Response codes carried in response byte seven
`define MHS_CODE_DSR_DROP       8'h01
`define MHS_CODE_CTS_FAIL       8'h02
`define MHS_CODE_RESET          8'h00

`endif

/* File: tb/mhs_modem_model.sv */
/*
 * Modem model for the supervisor's control circuits.
 * Assumes mode 0 answers RTS slowly, 1 never answers, 2 holds CTS on.
 */
`timescale 1ns/1ns

module mhs_modem_model (
    // Clock and reset
    input  wire       core_clk_in,
    input  wire       nrst_in,
    // Behaviour
    input  wire [1:0] mode_in,
    input  wire       dsr_on_in,
    // Circuits
    input  wire       rts_in,
    output reg        dsr_out,
    output reg        cts_out
);
    reg [3:0] dly_q;

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dsr_out <= 1'b0;
            cts_out <= 1'b0;
            dly_q   <= 4'h0;
        end else begin
            dsr_out <= dsr_on_in;
            dly_q   <= !rts_in ? 4'h0 : (dly_q == 4'h8 ? dly_q : dly_q + 4'h1);
            case (mode_in)
                2'h0: cts_out <= rts_in && dly_q == 4'h8;
                2'h2: cts_out <= 1'b1;
                default: cts_out <= 1'b0;
            endcase
        end
    end
endmodule // mhs_modem_model

/* File: tb/mhs_supervisor_bench.sv */
/*
 * Self-checking bench of the modem handshake supervisor with a modem model.
 * Assumes a shortened tick of 10 cycles; the CTS timeout stays 3000 ticks.
 */
`timescale 1ns/1ns
`include "mhs_map.vh"

module mhs_supervisor_bench;
    localparam TICK = 10;
    logic       core_clk_in = 1'b0;
    logic       nrst_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic       reg_wr_in = 1'b0;
    logic       reg_rd_in = 1'b0;
    logic [1:0] mode = 2'h0;
    logic       dsr_on = 1'b0;
    wire  [7:0] reg_rdata_out;
    wire        dsr_in, cts_in, rts_out, dtr_out, tx_enable_out, rx_enable_out;
    wire        resync_out, idle_out, event_valid_out;
    wire  [6:0] obs = {idle_out, resync_out, rx_enable_out, event_valid_out, tx_enable_out,
                       rts_out, dtr_out};
    int         n_errors = 0;
    int         n_compared = 0;

    always #25 core_clk_in = ~core_clk_in;

    mhs_supervisor #(.TICK_CYCLES(TICK)) dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .dsr_in(dsr_in),
        .cts_in(cts_in), .rts_out(rts_out), .dtr_out(dtr_out),
        .tx_enable_out(tx_enable_out), .rx_enable_out(rx_enable_out),
        .resync_out(resync_out), .idle_out(idle_out), .event_valid_out(event_valid_out));

    mhs_modem_model modem (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .mode_in(mode),
        .dsr_on_in(dsr_on), .rts_in(rts_out), .dsr_out(dsr_in), .cts_out(cts_in));

    task conclude;
        if (n_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task rd(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk(nm, e, reg_rdata_out);
    endtask

    // Bounded wait for one observed output to reach a level
    task wt(input int i, input logic v, input int lim);
        int k;
        #1;
        k = 0;
        while (obs[i] !== v && k < lim) begin
            @(posedge core_clk_in);
            #1;
            k++;
        end
        chk($sformatf("output %0d", i), {7'h00, v}, {7'h00, obs[i]});
        if (obs[i] !== v)
            conclude;
    endtask

    initial begin
        repeat (20) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        #1;
        chk("reset outputs", 8'h10, {1'b0, obs});
        rd("state", `MHS_REG_STATE, 8'h00);
        rd("unmapped", 8'h1c, 8'h00);
        wr(`MHS_REG_CTRL, 8'h05);
        rd("ctrl", `MHS_REG_CTRL, 8'h05);
        repeat (60 * TICK) @(posedge core_clk_in);
        #1;
        chk("rts tx without dsr", 8'h00, {6'h00, tx_enable_out, rts_out});
        rd("state waiting", `MHS_REG_STATE, 8'h01);
        rd("no event", `MHS_REG_RESP_STAT, 8'h00);
        wr(`MHS_REG_MODEM, 8'h01);
        wt(0, 1'b1, 4);
        dsr_on <= 1'b1;
        wt(1, 1'b1, 8);
        chk("tx before cts", 8'h00, {7'h00, tx_enable_out});
        wt(2, 1'b1, 20);
        wr(`MHS_REG_CTRL, 8'h07);
        wt(4, 1'b0, 4);
        wr(`MHS_REG_CTRL, 8'h05);
        wt(4, 1'b1, 4);
        dsr_on <= 1'b0;
        wt(5, 1'b1, 4 * TICK);
        wt(6, 1'b1, 2);
        wt(0, 1'b0, 2);
        wt(3, 1'b1, 2);
        chk("dtr rts after drop", 8'h00, {6'h00, rts_out, dtr_out});
        rd("dsr code", `MHS_REG_RESP_BYTE7, `MHS_CODE_DSR_DROP);
        rd("popped", `MHS_REG_RESP_STAT, 8'h00);
        rd("status", `MHS_REG_STATUS, 8'h40);
        wr(`MHS_REG_CTRL, 8'h15);
        wt(0, 1'b1, 4);
        mode <= 2'h2;
        wr(`MHS_REG_MODEM, 8'h01);
        rd("modem", `MHS_REG_MODEM, 8'h01);
        dsr_on <= 1'b1;
        repeat (5) @(posedge core_clk_in);
        #1;
        chk("rts under constant cts", 8'h00, {7'h00, rts_out});
        wt(1, 1'b1, 4 * TICK);
        wr(`MHS_REG_CTRL, 8'h0d);
        mode <= 2'h1;
        wt(3, 1'b1, 3010 * TICK);
        wt(5, 1'b1, 2);
        wt(6, 1'b1, 2);
        wt(0, 1'b0, 2);
        repeat (6) @(posedge core_clk_in);
        #1;
        chk("dtr back", 8'h01, {7'h00, dtr_out});
        rd("cts code", `MHS_REG_RESP_BYTE7, `MHS_CODE_CTS_FAIL);
        // Boot in progress brings DTR back after a DSR drop
        wr(`MHS_REG_CTRL, 8'h25);
        dsr_on <= 1'b0;
        wt(0, 1'b0, 4 * TICK);
        wt(0, 1'b1, 2);
        wr(`MHS_REG_CTRL, 8'h80);
        wt(0, 1'b0, 4);
        chk("rts after clear", 8'h00, {7'h00, rts_out});
        rd("ctrl cleared", `MHS_REG_CTRL, 8'h00);
        conclude;
    end
endmodule // mhs_supervisor_bench

bind mhs_supervisor mhs_supervisor_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .dsr_in(dsr_in), .cts_in(cts_in), .rts_out(rts_out),
    .dtr_out(dtr_out), .tx_enable_out(tx_enable_out), .rx_enable_out(rx_enable_out),
    .resync_out(resync_out), .idle_out(idle_out), .event_valid_out(event_valid_out));

/* File: tb/mhs_supervisor_monitor.sv */
/*
 * Checker of the modem handshake supervisor port relations.
 * Assumes binding to mhs_supervisor and one clock domain.
 */
`timescale 1ns/1ns
`include "mhs_map.vh"

module mhs_supervisor_monitor #(
    parameter TICK_CYCLES = 20
) (
    // Clock and reset
    input wire       core_clk_in,
    input wire       nrst_in,
    // Register port
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire       reg_wr_in,
    input wire       reg_rd_in,
    input wire [7:0] reg_rdata_out,
    // Modem circuits and line unit control
    input wire       dsr_in,
    input wire       cts_in,
    input wire       rts_out,
    input wire       dtr_out,
    input wire       tx_enable_out,
    input wire       rx_enable_out,
    input wire       resync_out,
    input wire       idle_out,
    input wire       event_valid_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);

    tx_interlock_a: assert property (tx_enable_out |-> $past(dsr_in) && $past(cts_in)
        && rts_out && dtr_out) else $error("transmit enabled without handshake");
    rx_blind_a: assert property (!rx_enable_out |-> rts_out)
        else $error("receiver blinded without request to send");
    dsr_recover_a: assert property (resync_out && !event_valid_out
        |=> idle_out ##1 !dtr_out ##1 event_valid_out) else $error("dsr recovery order wrong");
    cts_recover_a: assert property ($rose(event_valid_out) ##1 resync_out
        |=> idle_out ##1 !dtr_out) else $error("cts recovery order wrong");
    idle_after_a: assert property (idle_out |-> $past(resync_out))
        else $error("idle pulse without resync");
    dtr_rise_a: assert property ($rose(dtr_out) |-> $past(reg_wr_in)
        || $past(reg_wr_in, 2) || $past(dtr_out, 2)) else $error("dtr rose without cause");
    master_clear_a: assert property (reg_wr_in && reg_addr_in == `MHS_REG_CTRL
        && reg_wdata_in[7] |-> ##[1:2] !dtr_out && !rts_out) else $error("master clear kept dtr");
    event_pop_a: assert property ($fell(event_valid_out) |-> $past(reg_rd_in)
        && $past(reg_addr_in) == `MHS_REG_RESP_BYTE7) else $error("event lost without read");

    cover property (resync_out);
    cover property (!rx_enable_out);
    cover property ($rose(tx_enable_out));
endmodule // mhs_supervisor_monitor

/* File: verilog/mhs_supervisor.v */
/*
 * Modem handshake supervisor: DSR interlock and drop detection, RTS/CTS
 * sequence with its timeouts, DTR control and disconnect reporting.
 * Assumes dsr_in and cts_in are synchronous to core_clk_in and a host
 * register port with read data one cycle after the read strobe.
 */
// Chosen here: the address-and-strobe port and the register addresses.
// Functional notes
// - No transmission while DSR is off, even after line start.
// - No timeout while waiting for the first DSR; wait forever.
// - DSR off 10 ms after seen: resync, idle, drop DTR, queue event.
// - Host write of modem control reasserts DTR after a disconnect.
// - RTS already on skips check; CTS on waits 10-20 ms then RTS.
// - Transmission waits for CTS; 30 s timeout gives CTS failure.
// - With RTS on, CTS sampled each 10 ms; 30 s off fails.
// - Half duplex: RTS AND half-duplex disables the receiver.
// - CTS failure code is placed in response byte seven.
// - DTR cleared on power-up reset and on master clear.
// - After error drop, DTR returns on auto answer, remote load or boot.
`timescale 1ns/1ns
`include "mhs_map.vh"

module mhs_supervisor #(
    parameter TICK_CYCLES = `MHS_TICK_CYCLES
) (
    // Clock and reset
    input  wire       core_clk_in,
    input  wire       nrst_in,
    // Register port
    input  wire [7:0] reg_addr_in,
    input  wire [7:0] reg_wdata_in,
    input  wire       reg_wr_in,
    input  wire       reg_rd_in,
    output reg  [7:0] reg_rdata_out,
    // Modem circuits
    input  wire       dsr_in,
    input  wire       cts_in,
    output reg        rts_out,
    output reg        dtr_out,
    // Line unit control
    output reg        tx_enable_out,
    output reg        rx_enable_out,
    output reg        resync_out,
    output reg        idle_out,
    output reg        event_valid_out
);

    localparam [2:0] ST_IDLE     = 3'd0;
    localparam [2:0] ST_WAIT_DSR = 3'd1;
    localparam [2:0] ST_READY    = 3'd2;
    localparam [2:0] ST_CTS_CHK  = 3'd3;
    localparam [2:0] ST_RTS_ON   = 3'd4;
    localparam [2:0] ST_RECOVER  = 3'd5;

    localparam [31:0]              CTS_TO_32    = `MHS_CTS_TIMEOUT_TICKS;
    localparam [31:0]              CTS_CONST_32 = `MHS_CTS_CONST_TICKS;
    localparam [`MHS_TO_CNT_W-1:0] CTS_TO       = CTS_TO_32[`MHS_TO_CNT_W-1:0];
    localparam [`MHS_TO_CNT_W-1:0] CTS_CONST    = CTS_CONST_32[`MHS_TO_CNT_W-1:0];

    // Recovery actions {queue, drop_dtr, idle, resync} per cause and step
    function [3:0] rec_action;
        input       cts_cause;
        input [1:0] step;
        begin
            case ({cts_cause, step})
                3'b100:  rec_action = 4'b1000;
                3'b101:  rec_action = 4'b0001;
                3'b110:  rec_action = 4'b0010;
                3'b111:  rec_action = 4'b0100;
                3'b000:  rec_action = 4'b0001;
                3'b001:  rec_action = 4'b0010;
                3'b010:  rec_action = 4'b0100;
                default: rec_action = 4'b1000;
            endcase
        end
    endfunction

    wire                      tick;
    reg  [7:0]                ctrl_q;
    reg  [2:0]                state_q,  state_d;
    reg  [1:0]                step_q,   step_d;
    reg                       cause_q,  cause_d;
    reg  [`MHS_TO_CNT_W-1:0]  cnt_q,    cnt_d;
    reg                       rts_d;
    reg                       dsr_seen_q, dsr_seen_d;
    reg                       dsr_low_q;
    reg                       err_drop_q, err_drop_d;
    reg                       dtr_d;
    reg                       resp_ovr_q;
    reg  [7:0]                resp_code_q;
    reg  [3:0]                act;

    mhs_tick #(
        .CNT_W       (`MHS_TICK_CNT_W),
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .core_clk_in (core_clk_in),
        .nrst_in     (nrst_in),
        .tick_out    (tick)
    );

    wire mclr     = reg_wr_in && reg_addr_in == `MHS_REG_CTRL
                    && reg_wdata_in[`MHS_CTRL_MASTER_CLEAR];
    wire modem_wr = reg_wr_in && reg_addr_in == `MHS_REG_MODEM;
    wire pop      = reg_rd_in && reg_addr_in == `MHS_REG_RESP_BYTE7;
    wire line_on  = ctrl_q[`MHS_CTRL_LINE_START];
    wire tx_req   = ctrl_q[`MHS_CTRL_TX_REQ];
    wire half_dup = ctrl_q[`MHS_CTRL_HALF_DUPLEX];

    // DSR low at two successive ticks with no rise between: 10 ms off
    wire dsr_drop = tick && !dsr_in && dsr_low_q && dsr_seen_q
                    && state_q != ST_RECOVER;

    // Main sequencer
    always @* begin
        state_d    = state_q;
        step_d     = step_q;
        cause_d    = cause_q;
        cnt_d      = cnt_q;
        rts_d      = rts_out;
        dsr_seen_d = dsr_seen_q;
        act        = 4'b0000;
        case (state_q)
            ST_IDLE: begin
                rts_d = 1'b0;
                if (line_on) begin
                    state_d = ST_WAIT_DSR;
                end
            end
            ST_WAIT_DSR: begin
                // No timer here; host software owns this wait
                if (dsr_in && dtr_out) begin
                    dsr_seen_d = 1'b1;
                    state_d    = ST_READY;
                end
            end
            ST_READY: begin
                rts_d = 1'b0;
                if (tx_req) begin
                    cnt_d = {`MHS_TO_CNT_W{1'b0}};
                    if (rts_out || !cts_in) begin
                        rts_d   = 1'b1;
                        state_d = ST_RTS_ON;
                    end else begin
                        state_d = ST_CTS_CHK;
                    end
                end
            end
            ST_CTS_CHK: begin
                // Second tick boundary falls 10 to 20 ms after entry
                if (!tx_req) begin
                    state_d = ST_READY;
                end else if (!cts_in || cnt_q == CTS_CONST) begin
                    rts_d   = 1'b1;
                    cnt_d   = {`MHS_TO_CNT_W{1'b0}};
                    state_d = ST_RTS_ON;
                end else if (tick) begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ST_RTS_ON: begin
                if (!tx_req) begin
                    rts_d   = 1'b0;
                    state_d = ST_READY;
                end else if (tick) begin
                    if (cts_in) begin
                        cnt_d = {`MHS_TO_CNT_W{1'b0}};
                    end else if (cnt_q == CTS_TO - 1'b1) begin
                        cause_d = 1'b1;
                        step_d  = 2'd0;
                        rts_d   = 1'b0;
                        state_d = ST_RECOVER;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
            end
            ST_RECOVER: begin
                act    = rec_action(cause_q, step_q);
                step_d = step_q + 1'b1;
                if (step_q == 2'd3) begin
                    dsr_seen_d = 1'b0;
                    state_d    = ST_WAIT_DSR;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (dsr_drop) begin
            cause_d = 1'b0;
            step_d  = 2'd0;
            rts_d   = 1'b0;
            state_d = ST_RECOVER;
        end
        if (mclr || (!line_on && state_q != ST_RECOVER)) begin
            rts_d      = 1'b0;
            dsr_seen_d = 1'b0;
            state_d    = ST_IDLE;
        end
    end

    // DTR control
    always @* begin
        dtr_d      = dtr_out;
        err_drop_d = err_drop_q;
        if (mclr) begin
            dtr_d      = 1'b0;
            err_drop_d = 1'b0;
        end else if (act[2]) begin
            dtr_d      = 1'b0;
            err_drop_d = 1'b1;
        end else if (modem_wr) begin
            dtr_d      = reg_wdata_in[`MHS_MODEM_DTR];
            err_drop_d = 1'b0;
        end else if (err_drop_q && (ctrl_q[`MHS_CTRL_AUTO_ANSWER]
                     || ctrl_q[`MHS_CTRL_REMOTE_LOAD] || ctrl_q[`MHS_CTRL_BOOT])) begin
            dtr_d      = 1'b1;
            err_drop_d = 1'b0;
        end
    end

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q         <= ST_IDLE;
            step_q          <= 2'd0;
            cause_q         <= 1'b0;
            cnt_q           <= {`MHS_TO_CNT_W{1'b0}};
            dsr_seen_q      <= 1'b0;
            dsr_low_q       <= 1'b0;
            err_drop_q      <= 1'b0;
            ctrl_q          <= `MHS_CTRL_RESET;
            rts_out         <= 1'b0;
            dtr_out         <= 1'b0;
            tx_enable_out   <= 1'b0;
            rx_enable_out   <= 1'b1;
            resync_out      <= 1'b0;
            idle_out        <= 1'b0;
            event_valid_out <= 1'b0;
            resp_ovr_q      <= 1'b0;
            resp_code_q     <= `MHS_CODE_RESET;
            reg_rdata_out   <= 8'h00;
        end else begin
            state_q    <= state_d;
            step_q     <= step_d;
            cause_q    <= cause_d;
            cnt_q      <= cnt_d;
            dsr_seen_q <= dsr_seen_d;
            err_drop_q <= err_drop_d;
            rts_out    <= rts_d;
            dtr_out    <= dtr_d;
            if (dsr_in) begin
                dsr_low_q <= 1'b0;
            end else if (tick) begin
                dsr_low_q <= 1'b1;
            end
            if (reg_wr_in && reg_addr_in == `MHS_REG_CTRL) begin
                ctrl_q <= reg_wdata_in & `MHS_CTRL_MASK;
            end
            // Transmit only with DSR, DTR and returned CTS
            tx_enable_out <= state_d == ST_RTS_ON && rts_d && cts_in
                             && dsr_in && dtr_d;
            rx_enable_out <= !(rts_d && half_dup);
            resync_out    <= act[0];
            idle_out      <= act[1];
            // Event queue: a new event wins over a pop in the same cycle
            if (act[3]) begin
                event_valid_out <= 1'b1;
                resp_ovr_q      <= event_valid_out && !pop;
                resp_code_q     <= cause_q ? `MHS_CODE_CTS_FAIL
                                           : `MHS_CODE_DSR_DROP;
            end else if (pop) begin
                event_valid_out <= 1'b0;
                resp_ovr_q      <= 1'b0;
            end
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `MHS_REG_CTRL:       reg_rdata_out <= ctrl_q;
                    `MHS_REG_MODEM:      reg_rdata_out <= {7'h00, dtr_out};
                    `MHS_REG_STATUS:     reg_rdata_out <= {1'b0, err_drop_q, dsr_seen_q,
                                                           tx_enable_out, dtr_out, rts_out,
                                                           cts_in, dsr_in};
                    `MHS_REG_RESP_STAT:  reg_rdata_out <= {6'h00, resp_ovr_q,
                                                           event_valid_out};
                    `MHS_REG_RESP_BYTE7: reg_rdata_out <= resp_code_q;
                    `MHS_REG_STATE:      reg_rdata_out <= {5'h00, state_q};
                    default:             reg_rdata_out <= 8'h00;
                endcase
            end else begin
                reg_rdata_out <= 8'h00;
            end
        end
    end

endmodule // mhs_supervisor

/* File: verilog/mhs_tick.v */
/*
 * Shared timebase divider: one-cycle tick every TICK_CYCLES clocks.
 * Assumes a single free-running clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ns

module mhs_tick #(
    parameter CNT_W       = 18,
    parameter TICK_CYCLES = 200000
) (
    // Clock and reset
    input  wire core_clk_in,
    input  wire nrst_in,
    // Tick
    output reg  tick_out
);

    localparam [31:0]      LAST_32 = TICK_CYCLES - 1;
    localparam [CNT_W-1:0] LAST    = LAST_32[CNT_W-1:0];

    reg [CNT_W-1:0] cnt_q;

    always @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_q    <= {CNT_W{1'b0}};
            tick_out <= 1'b0;
        end else if (cnt_q == LAST) begin
            cnt_q    <= {CNT_W{1'b0}};
            tick_out <= 1'b1;
        end else begin
            cnt_q    <= cnt_q + 1'b1;
            tick_out <= 1'b0;
        end
    end

endmodule // mhs_tick
